//--- clk_cfg_pkg.sv
// Purpose: Constants for the core clock and L2 clock configuration block.
// Assumes: One 20 MHz system clock; straps and control inputs synchronous to it.
// Notes: Clocks are modelled as enable pulses and ratio codes, not analog outputs.
package clk_cfg_pkg;
	// Multiplier held in half steps: value 4 means 2x
	typedef logic [4:0] half_mult_t;
	localparam logic [3:0] CFG_X2 = 4'h4;
	localparam logic [3:0] CFG_X2P5 = 4'h6;
	localparam logic [3:0] CFG_X3 = 4'h8;
	localparam logic [3:0] CFG_X3P5 = 4'he;
	localparam logic [3:0] CFG_X4 = 4'ha;
	localparam logic [3:0] CFG_X4P5 = 4'h7;
	localparam logic [3:0] CFG_X5 = 4'hb;
	localparam logic [3:0] CFG_X5P5 = 4'h9;
	localparam logic [3:0] CFG_X6 = 4'hd;
	localparam logic [3:0] CFG_X6P5 = 4'h5;
	localparam logic [3:0] CFG_X7 = 4'h2;
	localparam logic [3:0] CFG_X7P5 = 4'h1;
	localparam logic [3:0] CFG_X8 = 4'hc;
	localparam logic [3:0] CFG_X9 = 4'h0;
	localparam logic [3:0] CFG_BYPASS = 4'h3;
	localparam logic [3:0] CFG_OFF = 4'hf;
	localparam half_mult_t HM_NONE = 5'h00;
	localparam half_mult_t HM_ONE = 5'h02;
	// VCO to core ratio in every multiplying setting
	localparam logic [1:0] VCO_RATIO = 2'h2;
	// L2 divisor field codes, divisor = (code+2)/2
	localparam logic [2:0] L2DIV_1 = 3'h0;
	localparam logic [2:0] L2DIV_4 = 3'h6;
	localparam int L2_SLOW_MHZ = 150;
	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_BYPASS = 3'b010,
		MODE_PLL = 3'b100
	} clk_mode_t;
endpackage

//--- core_pll_l2_clock_config.sv
// Purpose: Decode the clock strap into a core clock mode and divide core ticks into L2 clock.
// Assumes: core_tick_in marks each core clock half period (both edges) from the PLL model.
// Assumes: straps and the divisor code are synchronous to sys_clk_in.
// Notes: Strap is caught on the clock edge where reset is active, so it holds after release.
// Notes: Half-integer divisors give halves one tick apart; the average rate is exact.
// Notes: Analog loop behaviour is not modelled; the feedback return is only monitored.
`timescale 1ns/1ns
module core_pll_l2_clock_config
	import clk_cfg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	// Straps
	input wire logic [3:0] pll_cfg_in,
	// L2 control register fields
	input wire logic [2:0] l2_clock_divisor_field_in,
	input wire logic l2_slow_clock_select_in,
	// Core clock half-period ticks and feedback return
	input wire logic core_tick_in,
	input wire logic l2_feedback_clock_in,
	// Clock mode results
	output logic [2:0] clk_mode_out,
	output clk_cfg_pkg::half_mult_t half_mult_out,
	output logic [5:0] vco_half_mult_out,
	output logic cfg_reserved_out,
	// L2 clock
	output logic l2_clk_out,
	output logic l2_feedback_clock_out,
	output logic l2_phase_late_out,
	output logic l2_slow_out
);
	import clk_cfg_pkg::*;

	typedef struct packed {
		// Decoded strap results
		clk_mode_t mode;
		half_mult_t hm;
		logic [5:0] vco;
		logic rsv;
		// L2 divider: held divisor code, tick count in this half, clock level
		logic [2:0] div;
		logic [2:0] cnt;
		logic l2_clock_divisor_field;
		// Feedback drive, phase monitor and slow-clock mirror
		logic fb;
		logic late;
		logic slow;
	} state_t;

	state_t s, next_s;

	// Half-step multiplier for a strap code; zero means no multiplying clock
	function automatic half_mult_t decode(input logic [3:0] c);
		unique case (c)
			// Low multipliers
			CFG_X2: decode = 5'd4;
			CFG_X2P5: decode = 5'd5;
			CFG_X3: decode = 5'd6;
			CFG_X3P5: decode = 5'd7;
			CFG_X4: decode = 5'd8;
			// Middle multipliers
			CFG_X4P5: decode = 5'd9;
			CFG_X5: decode = 5'd10;
			CFG_X5P5: decode = 5'd11;
			CFG_X6: decode = 5'd12;
			// High multipliers
			CFG_X6P5: decode = 5'd13;
			CFG_X7: decode = 5'd14;
			CFG_X7P5: decode = 5'd15;
			CFG_X8: decode = 5'd16;
			CFG_X9: decode = 5'd18;
			// Clocks without the PLL
			CFG_BYPASS: decode = HM_ONE;
			CFG_OFF: decode = HM_NONE;
			default: decode = HM_NONE;
		endcase
	endfunction

	// Clock mode implied by a strap code
	function automatic clk_mode_t mode_of(input logic [3:0] c);
		if (c == CFG_OFF) begin
			mode_of = MODE_OFF;
		end else if (c == CFG_BYPASS) begin
			mode_of = MODE_BYPASS;
		end else if (decode(c) == HM_NONE) begin
			// Unlisted code: staying stopped is safer than guessing a rate
			mode_of = MODE_OFF;
		end else begin
			mode_of = MODE_PLL;
		end
	endfunction

	// Flags a code that decodes to nothing yet is not the off code
	function automatic logic reserved_of(input logic [3:0] c);
		reserved_of = (c != CFG_OFF) && (decode(c) == HM_NONE);
	endfunction

	// VCO multiple in half steps; zero whenever the PLL is not running
	function automatic logic [5:0] vco_of(input clk_mode_t m, input half_mult_t h);
		// Every multiplying setting runs the VCO at twice the core
		if (m == MODE_PLL) begin
			vco_of = 6'(h * VCO_RATIO);
		end else begin
			vco_of = 6'h00;
		end
	endfunction

	// Codes above the largest divisor are held at the largest one
	function automatic logic [2:0] clamp_div(input logic [2:0] code);
		// Larger codes are not supported divisors; clamping keeps the count in range
		if (code > L2DIV_4) begin
			clamp_div = L2DIV_4;
		end else begin
			clamp_div = code;
		end
	endfunction

	// A code gives a full L2 period of (code+2) core half periods.
	// The low half is rounded down, the high half up, so odd totals
	// differ by one tick per half and the average rate stays exact.
	function automatic logic [2:0] low_last(input logic [2:0] code);
		low_last = code >> 1;
	endfunction

	function automatic logic [2:0] high_last(input logic [2:0] code);
		high_last = 3'((4'(code) + 4'h1) >> 1);
	endfunction

	// Count value at which the current half of the L2 clock ends
	function automatic logic [2:0] half_last(input logic [2:0] code, input logic level);
		if (level) begin
			half_last = high_last(code);
		end else begin
			half_last = low_last(code);
		end
	endfunction

	// A tick counts only while the core clock is running at all
	function automatic logic tick_taken(input clk_mode_t m, input logic tick);
		tick_taken = (m != MODE_OFF) && tick;
	endfunction

	// Next tick count within the current half
	function automatic logic [2:0] count_up(input logic [2:0] cnt);
		count_up = 3'(cnt + 3'h1);
	endfunction

	// State loaded while reset is held: strap decoded, L2 side quiet at the smallest divisor
	function automatic state_t reset_state(input logic [3:0] c);
		state_t r;
		// Reserved codes come out as off with the flag set
		r.mode = mode_of(c);
		r.hm = decode(c);
		r.rsv = reserved_of(c);
		r.vco = vco_of(mode_of(c), decode(c));
		r.div = L2DIV_1;
		r.cnt = 3'h0;
		r.l2_clock_divisor_field = 1'b0;
		r.fb = 1'b0;
		r.late = 1'b0;
		r.slow = 1'b0;
		reset_state = r;
	endfunction

	// End of a half: flip the clock, restart the count, take the new divisor.
	// Taking the divisor only here keeps a runt half off the SRAM clock.
	function automatic state_t flip_state(input state_t st, input logic [2:0] code);
		state_t r;
		r = st;
		r.cnt = 3'h0;
		r.l2_clock_divisor_field = ~st.l2_clock_divisor_field;
		r.fb = ~st.l2_clock_divisor_field;
		r.div = clamp_div(code);
		flip_state = r;
	endfunction

	// Feedback still low while the clock is high: the far edge lags the internal one
	function automatic logic late_of(input logic level, input logic fb_back);
		late_of = level & ~fb_back;
	endfunction

	always_comb begin
		next_s = s;
		if (!rst_b_in) begin
			// Strap sampled on every edge while reset is held; later changes are ignored
			next_s = reset_state(pll_cfg_in);
		end else if (clk_en_in) begin
			next_s.slow = l2_slow_clock_select_in;
			// Off mode ignores ticks, so the L2 clock stays low
			if (tick_taken(s.mode, core_tick_in)) begin
				if (s.cnt == half_last(s.div, s.l2_clock_divisor_field)) begin
					next_s = flip_state(next_s, l2_clock_divisor_field_in);
				end else begin
					// Count ticks within the current half
					next_s.cnt = count_up(s.cnt);
				end
			end
			next_s.late = late_of(s.l2_clock_divisor_field, l2_feedback_clock_in);
		end
		// Clock enable low leaves every field as it is
	end

	// Reset still acts while the clock enable is low
	always_ff @(posedge sys_clk_in) begin
		s <= next_s;
	end

	// Strap results
	assign clk_mode_out = s.mode;
	assign half_mult_out = s.hm;
	assign vco_half_mult_out = s.vco;
	assign cfg_reserved_out = s.rsv;

	// L2 clock side
	assign l2_clk_out = s.l2_clock_divisor_field;
	assign l2_feedback_clock_out = s.fb;
	assign l2_phase_late_out = s.late;
	assign l2_slow_out = s.slow;
endmodule

//--- core_tick_model.sv
// Purpose: Core half-period ticks and board feedback return.
// Assumes: Ticks every cycle, or every other cycle when slow.
// Notes: Feedback comes back one cycle late, as a trace would.
`timescale 1ns/1ns
module core_tick_model(
	// Control
	input wire logic sys_clk_in,
	input wire logic run_in,
	input wire logic slow_in,
	input wire logic fb_out_in,
	// To the block
	output logic tick_out,
	output logic fb_ret_out = 1'b0
);
	logic ph = 1'b0;
	always_ff @(posedge sys_clk_in) begin
		ph <= ~ph;
		fb_ret_out <= fb_out_in;
	end
	assign tick_out = run_in && (!slow_in || ph);
endmodule

//--- core_pll_l2_clock_config_checker.sv
// Purpose: Port checks for the clock setup block.
// Assumes: Straps held steady through reset.
// Notes: Decode is judged on the first edge after release.
`timescale 1ns/1ns
module core_pll_l2_clock_config_checker
	import clk_cfg_pkg::*;
(
	// Inputs
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic [3:0] pll_cfg_in,
	input wire logic core_tick_in,
	// Outputs and the feedback return
	input wire logic [2:0] clk_mode_out,
	input wire clk_cfg_pkg::half_mult_t half_mult_out,
	input wire logic [5:0] vco_half_mult_out,
	input wire logic l2_clk_out,
	input wire logic l2_feedback_clock_out,
	input wire logic l2_feedback_clock_in,
	input wire logic l2_phase_late_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	vco_double_a: assert property (clk_mode_out == MODE_PLL |->
		vco_half_mult_out == {half_mult_out, 1'b0}) else $error("vco ratio wrong");
	x2_decode_a: assert property ($rose(rst_b_in) && $past(clk_en_in) &&
		$past(pll_cfg_in) == CFG_X2 |-> half_mult_out == 5'h04) else $error("x2 bad");
	x5_decode_a: assert property ($rose(rst_b_in) && $past(clk_en_in) &&
		$past(pll_cfg_in) == CFG_X5 |-> half_mult_out == 5'h0a) else $error("x5 bad");
	x9_decode_a: assert property ($rose(rst_b_in) && $past(clk_en_in) &&
		$past(pll_cfg_in) == CFG_X9 |-> half_mult_out == 5'h12) else $error("x9 bad");
	bypass_ratio_a: assert property (clk_mode_out == MODE_BYPASS |->
		half_mult_out == HM_ONE) else $error("bypass ratio wrong");
	off_quiet_a: assert property (clk_mode_out == MODE_OFF |=>
		$stable(l2_clk_out)) else $error("l2 clock moved while off");
	tick_only_a: assert property (!core_tick_in |=>
		$stable(l2_clk_out)) else $error("l2 clock moved without tick");
	fb_match_a: assert property ($changed(l2_clk_out) |->
		l2_feedback_clock_out == l2_clk_out) else $error("feedback out of step");
	late_flag_a: assert property ($past(rst_b_in) && $past(clk_en_in) |->
		l2_phase_late_out == $past(l2_clk_out && !l2_feedback_clock_in))
		else $error("phase late flag wrong");
endmodule
bind core_pll_l2_clock_config core_pll_l2_clock_config_checker i_chk(.sys_clk_in, .rst_b_in,
	.clk_en_in, .pll_cfg_in, .core_tick_in, .clk_mode_out, .half_mult_out,
	.vco_half_mult_out, .l2_clk_out, .l2_feedback_clock_out, .l2_feedback_clock_in,
	.l2_phase_late_out);

//--- core_pll_l2_clock_config_test.sv
// Purpose: Strap decode and L2 divider checks.
// Assumes: Inputs move 5 ns after each rising edge.
// Notes: Half periods are counted in system cycles.
`timescale 1ns/1ns
module core_pll_l2_clock_config_test;
	import clk_cfg_pkg::*;
	logic sys_clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, run = 1'b0, slow = 1'b0;
	logic [3:0] pll_cfg_in = CFG_X2; // Power-up strap is never the off code
	logic [2:0] div = L2DIV_1, mode;
	logic sel = 1'b0, tick, fb_in, rsv, l2, fb_out, l2s;
	half_mult_t hm;
	logic [5:0] vco;
	int num_errors = 0, compares = 0;
	localparam logic [4:0] hm_exp [16] = '{5'h12, 5'h0f, 5'h0e, 5'h02, 5'h04, 5'h0d, 5'h05,
		5'h09, 5'h06, 5'h0b, 5'h08, 5'h0a, 5'h10, 5'h0c, 5'h07, 5'h00};
	core_tick_model i_core(.sys_clk_in, .run_in(run), .slow_in(slow), .fb_out_in(fb_out),
		.tick_out(tick), .fb_ret_out(fb_in));
	core_pll_l2_clock_config i_dut(.sys_clk_in, .rst_b_in, .clk_en_in, .pll_cfg_in,
		.l2_clock_divisor_field_in(div), .l2_slow_clock_select_in(sel),
		.core_tick_in(tick), .l2_feedback_clock_in(fb_in), .clk_mode_out(mode),
		.half_mult_out(hm), .vco_half_mult_out(vco), .cfg_reserved_out(rsv),
		.l2_clk_out(l2), .l2_feedback_clock_out(fb_out), .l2_phase_late_out(),
		.l2_slow_out(l2s));
	initial forever #25 sys_clk_in = ~sys_clk_in;
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#5;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic do_reset(input logic [3:0] c);
		pll_cfg_in = c; // Listed codes only
		rst_b_in = 1'b0;
		step(5);
		rst_b_in = 1'b1;
		pll_cfg_in = ~c;
	endtask
	task automatic test_decode;
		for (int c = 0; c < 16; c++) begin
			do_reset(4'(c));
			step(2);
			chk(8'(hm), 8'(hm_exp[c]));
			chk(8'(mode), c == 15 ? 8'h01 : c == 3 ? 8'h02 : 8'h04);
			chk(8'(vco), (c == 15 || c == 3) ? 8'h00 : {2'h0, hm_exp[c], 1'b0});
			chk(8'(rsv), 8'h00);
		end
		run = 1'b1;
		step(20);
		chk(8'(l2), 8'h00);
	endtask
	task automatic wait_toggle(output int n);
		logic was;
		was = l2;
		n = 0;
		while (l2 === was && n < 40) begin
			step(1);
			n++;
		end
	endtask
	task automatic test_div(input logic [2:0] d, input logic s);
		int a, b;
		run = 1'b0;
		do_reset(CFG_X4);
		div = d;
		slow = s;
		sel = d > 3'h2; // Slow L2 rates flagged
		run = 1'b1;
		wait_toggle(a);
		wait_toggle(a);
		wait_toggle(a);
		wait_toggle(b);
		chk(8'(a + b), 8'((d > 6 ? 8 : d + 2) * (s ? 2 : 1)));
		chk(8'(a > b ? a - b : b - a), 8'(((d > 6 ? 8 : d + 2) % 2) * (s ? 2 : 1)));
		chk(8'(l2s), 8'(sel));
	endtask
	task automatic test_freeze;
		logic held, was_sel;
		test_div(3'h2, 1'b0);
		clk_en_in = 1'b0;
		held = l2;
		was_sel = sel;
		sel = ~sel;
		step(10);
		chk(8'(l2), 8'(held));
		chk(8'(l2s), 8'(was_sel));
		clk_en_in = 1'b1;
		step(10);
		chk(8'(l2s), 8'(sel));
	endtask
	task end_of_test;
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		step(1);
		test_decode;
		for (int d = 0; d < 8; d++)
			test_div(3'(d), 1'b0);
		test_div(3'h5, 1'b1);
		test_freeze;
		end_of_test;
	end
	initial begin
		#500000;
		num_errors++;
		end_of_test;
	end
endmodule
